// ---- rtl/irq_enable_mask.v ----
// Purpose: Interrupt enable masking between peripheral flags and core
// Assumes: All inputs synchronous to clk; plain register port
// Notes:   Priority resolution lives in the core, not here
//          Enable writes act from the cycle after the strobe
//          Status, mask and power-fail control sit beside the enable byte
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "irq_mask_defs.vh"

module irq_enable_mask
(
  input  wire                 clk,
  input  wire                 rst,
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`REG_W-1:0]    wdata,
  input  wire                 wr,
  input  wire                 rd,
  output reg  [`REG_W-1:0]    rdata,
  input  wire                 serial1_rx_done_flag,
  input  wire                 serial1_tx_done_flag,
  input  wire                 timer2_overflow_flag,
  input  wire                 serial0_rx_done_flag,
  input  wire                 serial0_tx_done_flag,
  input  wire                 timer1_overflow_flag,
  input  wire                 ext_irq1_req,
  input  wire                 timer0_overflow_flag,
  input  wire                 ext_irq0_req,
  input  wire                 powerfail_req,
  output wire [`SRC_N-1:0]    src_req,
  output wire                 powerfail_irq,
  output wire                 core_irq_req,
  output wire                 irq
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [`REG_W-1:0] interrupt_enable_mask_q;
  reg               powerfail_irq_enable_q;
  reg  [`EVT_N-1:0] irq_mask_q;
  wire [`EVT_N-1:0] irq_stat;
  wire [`SRC_N-1:0] src_flag;
  wire [`SRC_N-1:0] src_en;
  wire              global_irq_enable;
  wire              any_src;
  reg               core_req_prev_q;
  wire [`EVT_N-1:0] evt;
  wire              src_rise;
  wire              global_fall;

  // Bus decode
  reg               sel_en_mask;
  reg               sel_pf_ctrl;
  reg               sel_stat;
  reg               sel_mask;
  wire              wr_en_mask;
  wire              wr_pf;
  wire              wr_stat;
  wire              wr_mask;

  // Register next values
  reg  [`REG_W-1:0] interrupt_enable_mask_d;
  reg               powerfail_irq_enable_d;
  reg  [`EVT_N-1:0] irq_mask_d;

  // Read data
  reg  [`REG_W-1:0] rd_pf_ctrl;
  reg  [`REG_W-1:0] rd_stat;
  reg  [`REG_W-1:0] rd_mask;
  reg  [`REG_W-1:0] rdata_d;

  // ****************************************
  // Address decode
  // ****************************************
  // One-hot selects; an unmapped address selects nothing, so writes drop
  always @*
  begin
    sel_en_mask = 1'b0;
    sel_pf_ctrl = 1'b0;
    sel_stat    = 1'b0;
    sel_mask    = 1'b0;
    case (addr)
      `OFS_EN_MASK:
      begin
        sel_en_mask = 1'b1;
      end
      `OFS_PF_CTRL:
      begin
        sel_pf_ctrl = 1'b1;
      end
      `OFS_IRQ_STAT:
      begin
        sel_stat = 1'b1;
      end
      `OFS_IRQ_MASK:
      begin
        sel_mask = 1'b1;
      end
      default:
      begin
        sel_en_mask = 1'b0;
      end
    endcase
  end

  assign wr_en_mask = wr & sel_en_mask;
  assign wr_pf      = wr & sel_pf_ctrl;
  assign wr_stat    = wr & sel_stat;
  assign wr_mask    = wr & sel_mask;

  // ****************************************
  // Next register values
  // ****************************************
  // every enable bit freely writable
  always @*
  begin
    interrupt_enable_mask_d = interrupt_enable_mask_q;
    powerfail_irq_enable_d  = powerfail_irq_enable_q;
    irq_mask_d              = irq_mask_q;
    if (wr_en_mask)
    begin
      interrupt_enable_mask_d = wdata;
    end
    if (wr_pf)
    begin
      powerfail_irq_enable_d = wdata[`BIT_PF_EN];
    end
    if (wr_mask)
    begin
      irq_mask_d = wdata[`EVT_N-1:0];
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      interrupt_enable_mask_q <= `EN_MASK_RESET;
      powerfail_irq_enable_q  <= 1'b0;
      irq_mask_q              <= {`EVT_N{1'b0}};
    end
    else
    begin
      interrupt_enable_mask_q <= interrupt_enable_mask_d;
      powerfail_irq_enable_q  <= powerfail_irq_enable_d;
      irq_mask_q              <= irq_mask_d;
    end
  end

  // ****************************************
  // Source gating
  // ****************************************
  assign global_irq_enable = interrupt_enable_mask_q[`BIT_GLOBAL];

  // ****************************************
  // Flag collection
  // ****************************************
  // Each serial port has one enable, so its two done flags merge first
  // serial pairs ORed; flags held by software
  assign src_flag[`BIT_SERIAL1] = serial1_rx_done_flag | serial1_tx_done_flag;
  assign src_flag[`BIT_TIMER2]  = timer2_overflow_flag;
  assign src_flag[`BIT_SERIAL0] = serial0_rx_done_flag | serial0_tx_done_flag;
  assign src_flag[`BIT_TIMER1]  = timer1_overflow_flag;
  assign src_flag[`BIT_EXT1]    = ext_irq1_req;
  assign src_flag[`BIT_TIMER0]  = timer0_overflow_flag;
  assign src_flag[`BIT_EXT0]    = ext_irq0_req;

  // global gate on every individual enable
  assign src_en = interrupt_enable_mask_q[`SRC_N-1:0] & {`SRC_N{global_irq_enable}};

  // One gate per source enable bit (bits 6..0, not the global bit 7); bit order follows the enable byte
  genvar i;
  generate
    for (i = 0; i < `SRC_N; i = i + 1)
    begin : g_src
      src_gate i_src_gate
      (
        .flag   (src_flag[i]),
        .enable (src_en[i]),
        .req    (src_req[i])
      );
    end
  endgenerate

  // ****************************************
  // Power-fail path and core request
  // ****************************************
  // Outside the global gate so a failing supply is never masked by it
  // power-fail bypasses the global gate
  assign powerfail_irq = powerfail_req & powerfail_irq_enable_q;

  assign any_src      = |src_req;
  assign core_irq_req = any_src | powerfail_irq;

  // ****************************************
  // Event status and interrupt output
  // ****************************************
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core_req_prev_q <= 1'b0;
    end
    else
    begin
      core_req_prev_q <= any_src;
    end
  end

  // Rising edge only, so a flag held by software does not refire
  // the status bit after it has been cleared
  assign src_rise    = any_src & ~core_req_prev_q;
  // Software turned the global enable from on to off
  assign global_fall = wr_en_mask & ~wdata[`BIT_GLOBAL] & global_irq_enable;

  assign evt[`EVT_SRC_RISE] = src_rise;
  // Level event: power-fail keeps setting its bit while requested and enabled
  assign evt[`EVT_PF_LEVEL] = powerfail_irq;
  assign evt[`EVT_GLB_FALL] = global_fall;

  event_stat #(.N(`EVT_N)) i_event_stat
  (
    .clk      (clk),
    .rst      (rst),
    .event_in (evt),
    .clr_we   (wr_stat),
    .clr_bits (wdata[`EVT_N-1:0]),
    .stat_q   (irq_stat)
  );

  // Level output: high until software clears or masks the status bit
  assign irq = |(irq_stat & irq_mask_q);

  // ****************************************
  // Read port
  // ****************************************
  // Field placement per readable register; unused bits read as zero
  always @*
  begin
    rd_pf_ctrl             = {`REG_W{1'b0}};
    rd_pf_ctrl[`BIT_PF_EN] = powerfail_irq_enable_q;
    rd_stat                = {`REG_W{1'b0}};
    rd_stat[`EVT_N-1:0]    = irq_stat;
    rd_mask                = {`REG_W{1'b0}};
    rd_mask[`EVT_N-1:0]    = irq_mask_q;
  end

  // Unmapped reads return zero rather than stale bus data
  always @*
  begin
    rdata_d = {`REG_W{1'b0}};
    if (rd)
    begin
      case (addr)
        `OFS_EN_MASK:
        begin
          rdata_d = interrupt_enable_mask_q;
        end
        `OFS_PF_CTRL:
        begin
          rdata_d = rd_pf_ctrl;
        end
        `OFS_IRQ_STAT:
        begin
          rdata_d = rd_stat;
        end
        `OFS_IRQ_MASK:
        begin
          rdata_d = rd_mask;
        end
        default:
        begin
          rdata_d = {`REG_W{1'b0}};
        end
      endcase
    end
  end

  // Read data stand one cycle after the strobe, then drop to zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= {`REG_W{1'b0}};
    end
    else
    begin
      rdata <= rdata_d;
    end
  end

endmodule

// ---- inc/irq_mask_defs.vh ----
// Purpose: Constants for the interrupt enable masking block
// Assumes: Included by bare name from the enable masking rtl only
// Notes:   Offsets are byte addresses on the plain register port
`ifndef IRQ_MASK_DEFS_VH
`define IRQ_MASK_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_W          8
`define OFS_EN_MASK     8'ha8
`define OFS_PF_CTRL     8'hc0
`define OFS_IRQ_STAT    8'hc1
`define OFS_IRQ_MASK    8'hc2

// ****************************************
// Field positions
// ****************************************
`define BIT_GLOBAL      7
`define BIT_SERIAL1     6
`define BIT_TIMER2      5
`define BIT_SERIAL0     4
`define BIT_TIMER1      3
`define BIT_EXT1        2
`define BIT_TIMER0      1
`define BIT_EXT0        0
`define BIT_PF_EN       5
`define EVT_SRC_RISE    0
`define EVT_PF_LEVEL    1
`define EVT_GLB_FALL    2

// ****************************************
// Reset values and widths
// ****************************************
`define EN_MASK_RESET   8'h00
`define REG_W           8
`define SRC_N           7
`define EVT_N           3

`endif

// ---- rtl/src_gate.v ----
// Purpose: One source's enable gate
// Assumes: Flag and enable are synchronous levels
// Notes:   Pure combinational
`timescale 1ns/100ps

module src_gate
(
  input  wire flag,
  input  wire enable,
  output wire req
);

  assign req = flag & enable;

endmodule

// ---- rtl/event_stat.v ----
// Purpose: Sticky event status bits with write-one-to-clear
// Assumes: Events are one-cycle or level, synchronous to clk
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/100ps

module event_stat
#(
  parameter N = 3
)
(
  input  wire         clk,
  input  wire         rst,
  input  wire [N-1:0] event_in,
  input  wire         clr_we,
  input  wire [N-1:0] clr_bits,
  output reg  [N-1:0] stat_q
);

  reg [N-1:0] stat_d;

  always @*
  begin
    stat_d = stat_q;
    if (clr_we)
    begin
      stat_d = stat_d & ~clr_bits;
    end
    stat_d = stat_d | event_in;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stat_q <= {N{1'b0}};
    end
    else
    begin
      stat_q <= stat_d;
    end
  end

endmodule

// ---- bench/irq_mask_monitor.sv ----
// Purpose: Port checks for the enable masking block
// Assumes: One clock, rst async active high
// Notes:   Enable byte mirrored from bus writes
`timescale 1ns/100ps

module irq_mask_monitor
(
  input wire       clk,
  input wire       rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata,
  input wire [6:0] src_req,
  input wire       powerfail_irq,
  input wire       core_irq_req,
  input wire       irq,
  input wire       powerfail_req,
  input wire       timer0_overflow_flag,
  input wire       ext_irq0_req
);
  reg [7:0] en_q;
  reg       pf_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Mirror kept here because the enable byte is not a port
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en_q <= 8'h00;
      pf_q <= 1'b0;
    end
    else if (wr && addr == 8'ha8)
    begin
      en_q <= wdata;
    end
    else if (wr && addr == 8'hc0)
    begin
      pf_q <= wdata[5];
    end
  end

  a_global_off: assert property (!en_q[7] |-> src_req == 7'h00) else $error("global");
  a_ser1_gate: assert property (!en_q[6] |-> !src_req[6]) else $error("ser1");
  a_tmr2_gate: assert property (!en_q[5] |-> !src_req[5]) else $error("tmr2");
  a_ser0_gate: assert property (!en_q[4] |-> !src_req[4]) else $error("ser0");
  a_tmr1_gate: assert property (!en_q[3] |-> !src_req[3]) else $error("tmr1");
  a_ext1_gate: assert property (!en_q[2] |-> !src_req[2]) else $error("ext1");
  a_tmr0_gate: assert property (!en_q[1] |-> !src_req[1]) else $error("tmr0");
  a_ext0_gate: assert property (!en_q[0] |-> !src_req[0]) else $error("ext0");
  a_read_back: assert property (rd && addr == 8'ha8 |=> rdata == $past(en_q)) else $error("rd");
  a_core_or: assert property (core_irq_req == (|src_req || powerfail_irq)) else $error("core");
  a_pf_gate: assert property (powerfail_irq == (powerfail_req && pf_q)) else $error("pf");
  a_tmr0_pass: assert property (en_q[7] & en_q[1] & timer0_overflow_flag |-> src_req[1])
    else $error("tmr0 pass");
  a_ext0_pass: assert property (en_q[7] & en_q[0] & ext_irq0_req |-> src_req[0])
    else $error("ext0 pass");
  cover property (src_req != 7'h00);
  cover property (irq);
  cover property (powerfail_irq && !en_q[7]);
  cover property (rd && addr == 8'ha8 ##1 rdata != 8'h00);
endmodule

bind irq_enable_mask irq_mask_monitor i_irq_mask_monitor (.*);

// ---- bench/flag_source_model.sv ----
// Purpose: Peripheral flag sources facing the mask block
// Assumes: Set and clear pulses from the bench
// Notes:   Set wins over clear
`timescale 1ns/100ps

module flag_source_model
(
  input  wire       clk,
  input  wire       rst,
  input  wire [9:0] set_v,
  input  wire [9:0] clr_v,
  output reg  [9:0] flags_q
);
  always @(posedge clk or posedge rst)
    if (rst)
      flags_q <= 10'h000;
    else
      flags_q <= (flags_q & ~clr_v) | set_v;
endmodule

// ---- bench/test_irq_enable_mask.sv ----
// Purpose: Register and gating tests for the enable masking block
// Assumes: Flags come from the flag source model
// Notes:   Flag bit j maps to source s below
`timescale 1ns/100ps

module test_irq_enable_mask;
  reg        clk, rst, wr, rd;
  reg  [7:0] addr, wdata;
  reg  [9:0] set_v, clr_v;
  wire [9:0] f;
  wire [7:0] rdata;
  wire [6:0] src_req;
  wire       pf_irq, core, irq;
  integer    fail_count, cmp_count, j, s;

  flag_source_model i_flag_source_model (.clk(clk), .rst(rst), .set_v(set_v),
    .clr_v(clr_v), .flags_q(f));
  irq_enable_mask i_irq_enable_mask (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .serial1_rx_done_flag(f[8]),
    .serial1_tx_done_flag(f[7]), .timer2_overflow_flag(f[6]), .serial0_rx_done_flag(f[5]),
    .serial0_tx_done_flag(f[4]), .timer1_overflow_flag(f[3]), .ext_irq1_req(f[2]),
    .timer0_overflow_flag(f[1]), .ext_irq0_req(f[0]), .powerfail_req(f[9]),
    .src_req(src_req), .powerfail_irq(pf_irq), .core_irq_req(core), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wreg(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task rchk(input [7:0] a, input [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask

  task ev(input [9:0] sv, input [9:0] cv);
    @(posedge clk);
    set_v <= sv;
    clr_v <= cv;
    @(posedge clk);
    set_v <= 10'h000;
    clr_v <= 10'h000;
    #1;
  endtask

  task results;
    $display("compares %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    fail_count = 0;
    cmp_count = 0;
    {rst, wr, rd, addr, wdata, set_v, clr_v} = {1'b1, 38'h0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(8'ha8, 8'h00);
    wreg(8'ha8, 8'hff);
    rchk(8'ha8, 8'hff);
    wreg(8'ha8, 8'h5a);
    rchk(8'ha8, 8'h5a);
    wreg(8'h10, 8'h33);
    rchk(8'h10, 8'h00);
    // Serial ports have two flags on one enable
    for (j = 0; j < 9; j = j + 1)
    begin
      s = j < 4 ? j : j < 6 ? 4 : j < 7 ? 5 : 6;
      ev(10'h001 << j, 10'h000);
      wreg(8'ha8, 8'h80 | (8'h01 << s));
      chk("src_on", src_req, 8'h01 << s);
      chk("core", core, 8'h01);
      wreg(8'ha8, 8'h7f);
      chk("src_glb", src_req, 8'h00);
      chk("core_glb", core, 8'h00);
      wreg(8'ha8, 8'h80 | ~(8'h01 << s));
      chk("src_off", src_req, 8'h00);
      ev(10'h000, 10'h001 << j);
    end
    wreg(8'ha8, 8'h00);
    wreg(8'hc0, 8'h20);
    ev(10'h200, 10'h000);
    chk("pf_irq", pf_irq, 8'h01);
    chk("core_pf", core, 8'h01);
    wreg(8'hc0, 8'h00);
    chk("pf_off", pf_irq, 8'h00);
    ev(10'h000, 10'h200);
    wreg(8'hc1, 8'h07);
    rchk(8'hc1, 8'h00);
    wreg(8'hc2, 8'h01);
    wreg(8'ha8, 8'h82);
    ev(10'h002, 10'h000);
    rchk(8'hc1, 8'h01);
    chk("irq", irq, 8'h01);
    wreg(8'hc2, 8'h00);
    chk("irq_msk", irq, 8'h00);
    wreg(8'hc2, 8'h01);
    wreg(8'hc1, 8'h01);
    chk("irq_clr", irq, 8'h00);
    chk("src_hold", src_req, 8'h02);
    wreg(8'ha8, 8'h02);
    rchk(8'hc1, 8'h04);
    // Mid-run reset clears the enable byte again
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("src_rst", src_req, 8'h00);
    chk("irq_rst", irq, 8'h00);
    rchk(8'ha8, 8'h00);
    results;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count = fail_count + 1;
    results;
  end
endmodule
